// >>> logic/wdg_top.sv
/*
 * Windowed guard timer with APB register slave, sticky interrupt status
 * and a chip reset request output.
 * Assumes rstn comes from pin, power-on and brown-out reset only; the
 * reset request of this block feeds the chip reset controller, so the
 * reset-cause flag survives the reset it causes.
 */
// Design decisions made here: the APB register port and the register offsets.
`timescale 1ns/1ps
module wdg_top #(
    parameter bit WINDOWED = 1'b1
) (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic internalRcOsc,
    input wire logic dedicatedGuardOsc,
    output logic guardIrq,
    output logic guardResetReq
);
    // ==========================================================
    // Declarations
    wdg_pkg::wdg_mode_t modeQ;
    logic [23:0] timeoutQ;
    logic [23:0] windowQ;
    logic [23:0] warnQ;
    logic [23:0] countQ;
    logic [1:0] clkSelQ;
    logic [wdg_pkg::ST_WIDTH-1:0] statusQ;
    logic [wdg_pkg::ST_WIDTH-1:0] intEnQ;
    logic [wdg_pkg::ST_WIDTH-1:0] statusSet;
    logic [wdg_pkg::ST_WIDTH-1:0] statusClr;
    logic [2:0] rstCntQ;
    logic tick;
    logic feedOk;
    logic feedBad;
    logic wrEn;
    logic setupRd;
    logic addrOk;
    logic keyWr;
    logic otherWr;
    logic zeroHit;
    logic faultEv;
    logic expireEv;
    logic warnEv;
    logic earlyFeed;
    logic [23:0] timeoutWr;
    logic [1:0] clkSelWr;

    // ==========================================================
    // APB slave: one wait-free access phase, answer ready at its first edge
    always_comb begin
        unique case (paddr)
            wdg_pkg::OFS_MODE, wdg_pkg::OFS_TIMEOUT, wdg_pkg::OFS_FEED,
            wdg_pkg::OFS_COUNT, wdg_pkg::OFS_CLKSEL, wdg_pkg::OFS_WINDOW,
            wdg_pkg::OFS_WARN, wdg_pkg::OFS_STATUS, wdg_pkg::OFS_INTCLR,
            wdg_pkg::OFS_INTEN: addrOk = 1'b1;
            default: addrOk = 1'b0;
        endcase
    end

    assign setupRd = psel & ~penable;
    assign wrEn = psel & penable & pready & pwrite & ~pslverr;
    assign keyWr = wrEn & (paddr == wdg_pkg::OFS_FEED);
    assign otherWr = wrEn & (paddr != wdg_pkg::OFS_FEED);

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end else begin
            pready <= setupRd;
            pslverr <= setupRd & ~addrOk;
            if (setupRd) begin
                prdata <= 32'h00000000;
                if (!pwrite) begin
                    unique case (paddr)
                        wdg_pkg::OFS_MODE: prdata <= {28'h0000000, modeQ};
                        wdg_pkg::OFS_TIMEOUT: prdata <= {8'h00, timeoutQ};
                        wdg_pkg::OFS_COUNT: prdata <= {8'h00, countQ};
                        wdg_pkg::OFS_CLKSEL: prdata <= {30'h00000000, clkSelQ};
                        wdg_pkg::OFS_WINDOW: prdata <= {8'h00, windowQ};
                        wdg_pkg::OFS_WARN: prdata <= {8'h00, warnQ};
                        wdg_pkg::OFS_STATUS: prdata <= {28'h0000000, statusQ};
                        wdg_pkg::OFS_INTEN: prdata <= {28'h0000000, intEnQ};
                        default: prdata <= 32'h00000000;
                    endcase
                end
            end
        end
    end

    // ==========================================================
    // Configuration registers
    // Short timeouts are raised to the minimum rather than rejected
    assign timeoutWr = (pwdata[23:0] < wdg_pkg::TIMEOUT_MIN) ? wdg_pkg::TIMEOUT_MIN
                                                            : pwdata[23:0];
    // Windowed variant has no main-clock path; that code falls back to RC
    assign clkSelWr = (pwdata[1:0] == wdg_pkg::CLKSEL_MAIN && WINDOWED) ? wdg_pkg::CLKSEL_RC
                    : (pwdata[1:0] > wdg_pkg::CLKSEL_MAIN) ? wdg_pkg::CLKSEL_RC
                    : pwdata[1:0];

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            timeoutQ <= wdg_pkg::TIMEOUT_RST;
            windowQ <= wdg_pkg::WINDOW_RST;
            warnQ <= wdg_pkg::WARN_RST;
            clkSelQ <= wdg_pkg::CLKSEL_RC;
            intEnQ <= '0;
        end else if (wrEn) begin
            unique case (paddr)
                wdg_pkg::OFS_TIMEOUT: timeoutQ <= timeoutWr;
                wdg_pkg::OFS_WINDOW: windowQ <= pwdata[23:0];
                wdg_pkg::OFS_WARN: warnQ <= pwdata[23:0];
                wdg_pkg::OFS_CLKSEL: clkSelQ <= clkSelWr;
                wdg_pkg::OFS_INTEN: intEnQ <= pwdata[wdg_pkg::ST_WIDTH-1:0];
                default: ;
            endcase
        end
    end

    // Enable is set-only from software; an expiry or a fault clears it
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            modeQ <= '0;
        end else begin
            if (wrEn && paddr == wdg_pkg::OFS_MODE) begin
                modeQ.enable <= modeQ.enable | pwdata[wdg_pkg::MODE_ENABLE_BIT];
                modeQ.resetEn <= pwdata[wdg_pkg::MODE_RESETEN_BIT];
                modeQ.windowEn <= pwdata[wdg_pkg::MODE_WINDOWEN_BIT];
                modeQ.warnEn <= pwdata[wdg_pkg::MODE_WARNEN_BIT];
            end
            if (expireEv || faultEv) begin
                modeQ.enable <= 1'b0;
            end
        end
    end

    // ==========================================================
    // Tick source and reload checker
    wdg_prescale #(
        .DIV(wdg_pkg::PRESCALE_DIV)
    ) u_prescale (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .internalRcOsc(internalRcOsc),
        .dedicatedGuardOsc(dedicatedGuardOsc),
        .clkSel(clkSelQ),
        .tick(tick)
    );

    wdg_feed_seq u_feed (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .keyWr(keyWr),
        .otherWr(otherWr),
        .keyData(pwdata[7:0]),
        .feedOk(feedOk),
        .feedBad(feedBad)
    );

    // ==========================================================
    // Down counter and its events
    assign earlyFeed = feedOk & modeQ.windowEn & (countQ > windowQ);
    assign faultEv = modeQ.enable & (feedBad | earlyFeed);
    assign zeroHit = modeQ.enable & tick & (countQ == 24'h000000) & ~feedOk;
    assign expireEv = zeroHit & ~faultEv;
    assign warnEv = modeQ.enable & modeQ.warnEn & tick & ~feedOk
                  & (countQ != 24'h000000) & (countQ - 24'h000001 == warnQ);

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            countQ <= wdg_pkg::TIMEOUT_RST;
        end else if (!modeQ.enable || feedOk || zeroHit) begin
            // Idle, reloaded or expired: counter restarts from the timeout
            countQ <= timeoutQ;
        end else if (tick) begin
            countQ <= countQ - 24'h000001;
        end
    end

    // ==========================================================
    // Chip reset request, held for a fixed pulse
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            rstCntQ <= 3'h0;
            guardResetReq <= 1'b0;
        end else if ((expireEv || faultEv) && modeQ.resetEn) begin
            rstCntQ <= 3'(wdg_pkg::RESET_PULSE_CYC - 1);
            guardResetReq <= 1'b1;
        end else if (rstCntQ != 3'h0) begin
            rstCntQ <= rstCntQ - 3'h1;
        end else begin
            guardResetReq <= 1'b0;
        end
    end

    // ==========================================================
    // Sticky status; a set in the same cycle as its clear wins
    always_comb begin
        statusSet = '0;
        statusSet[wdg_pkg::ST_TIMEOUT_BIT] = expireEv;
        statusSet[wdg_pkg::ST_FAULT_BIT] = faultEv;
        statusSet[wdg_pkg::ST_WARN_BIT] = warnEv;
        statusSet[wdg_pkg::ST_CAUSE_BIT] = (expireEv | faultEv) & modeQ.resetEn;
    end

    assign statusClr = (wrEn && paddr == wdg_pkg::OFS_INTCLR)
                     ? pwdata[wdg_pkg::ST_WIDTH-1:0] : '0;

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            statusQ <= '0;
        end else begin
            statusQ <= (statusQ & ~statusClr) | statusSet;
        end
    end

    // Cause flag is a record, not an interrupt source
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            guardIrq <= 1'b0;
        end else begin
            guardIrq <= |(statusQ & intEnQ & ~(4'h1 << wdg_pkg::ST_CAUSE_BIT));
        end
    end

    // ==========================================================
    // Checks
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);

    property p_enable_sticky;
        modeQ.enable && !expireEv && !faultEv |=> modeQ.enable;
    endproperty
    a_enable_sticky: assert property (p_enable_sticky) else $error("enable dropped");

    property p_timeout_reset;
        expireEv && modeQ.resetEn |=> guardResetReq && !modeQ.enable;
    endproperty
    a_timeout_reset: assert property (p_timeout_reset) else $error("no reset on timeout");

    property p_bad_feed;
        modeQ.enable && feedBad |=> statusQ[wdg_pkg::ST_FAULT_BIT] && !modeQ.enable;
    endproperty
    a_bad_feed: assert property (p_bad_feed) else $error("bad feed not flagged");

    property p_cause_flag;
        $rose(guardResetReq) |-> statusQ[wdg_pkg::ST_CAUSE_BIT];
    endproperty
    a_cause_flag: assert property (p_cause_flag) else $error("cause flag missing");

    property p_count_down;
        modeQ.enable && tick && !feedOk && !faultEv && countQ != 24'h000000
            |=> countQ == $past(countQ) - 24'h000001;
    endproperty
    a_count_down: assert property (p_count_down) else $error("counter step wrong");

    property p_timeout_min;
        timeoutQ >= wdg_pkg::TIMEOUT_MIN;
    endproperty
    a_timeout_min: assert property (p_timeout_min) else $error("timeout below minimum");

    property p_clk_choice;
        clkSelQ != 2'h3 && !(WINDOWED && clkSelQ == wdg_pkg::CLKSEL_MAIN);
    endproperty
    a_clk_choice: assert property (p_clk_choice) else $error("illegal clock source");

    property p_window;
        modeQ.enable && modeQ.windowEn && feedOk && countQ > windowQ
            |=> statusQ[wdg_pkg::ST_FAULT_BIT];
    endproperty
    a_window: assert property (p_window) else $error("early reload accepted");

    property p_warn;
        warnEv |=> statusQ[wdg_pkg::ST_WARN_BIT] && countQ == warnQ;
    endproperty
    a_warn: assert property (p_warn) else $error("warning wrong");

    property p_reset_pulse;
        $rose(guardResetReq) |-> guardResetReq [*4];
    endproperty
    a_reset_pulse: assert property (p_reset_pulse) else $error("reset pulse short");

    property p_irq_mode;
        expireEv && !modeQ.resetEn && intEnQ[wdg_pkg::ST_TIMEOUT_BIT] |=> ##1 guardIrq;
    endproperty
    a_irq_mode: assert property (p_irq_mode) else $error("timeout irq missing");

    property p_feed_reload;
        feedOk |=> countQ == $past(timeoutQ);
    endproperty
    a_feed_reload: assert property (p_feed_reload) else $error("reload value wrong");

    property p_tick_spacing;
        tick |=> !tick [*3];
    endproperty
    a_tick_spacing: assert property (p_tick_spacing) else $error("tick too frequent");

    property p_expire_reload;
        zeroHit |=> countQ == $past(timeoutQ) && !modeQ.enable;
    endproperty
    a_expire_reload: assert property (p_expire_reload) else $error("expiry not handled");

    property p_status_sticky;
        statusQ[wdg_pkg::ST_TIMEOUT_BIT] && !statusClr[wdg_pkg::ST_TIMEOUT_BIT]
            |=> statusQ[wdg_pkg::ST_TIMEOUT_BIT];
    endproperty
    a_status_sticky: assert property (p_status_sticky) else $error("status lost");

    property p_warn_irq;
        warnEv && intEnQ[wdg_pkg::ST_WARN_BIT] && !wrEn |=> ##1 guardIrq;
    endproperty
    a_warn_irq: assert property (p_warn_irq) else $error("warning irq missing");

    property p_irq_only_mode;
        !modeQ.resetEn |=> !$rose(guardResetReq);
    endproperty
    a_irq_only_mode: assert property (p_irq_only_mode) else $error("reset in irq mode");

    c_timeout: cover property (expireEv && modeQ.resetEn);
    c_good_feed: cover property (feedOk && modeQ.enable);
    c_fault: cover property (faultEv);
    c_warn: cover property (warnEv);
    c_early_feed: cover property (earlyFeed && modeQ.enable);
endmodule

// >>> inc/wdg_pkg.sv
/*
 * Shared constants and types of the windowed guard timer: register map,
 * field positions, reset values, key values and timing counts.
 * Assumes a 32-bit APB register bus and a 50 MHz sys_clk.
 */
package wdg_pkg;

    // ==========================================================
    // Register byte offsets
    localparam logic [7:0] OFS_MODE = 8'h00;
    localparam logic [7:0] OFS_TIMEOUT = 8'h04;
    localparam logic [7:0] OFS_FEED = 8'h08;
    localparam logic [7:0] OFS_COUNT = 8'h0C;
    localparam logic [7:0] OFS_CLKSEL = 8'h10;
    localparam logic [7:0] OFS_WINDOW = 8'h14;
    localparam logic [7:0] OFS_WARN = 8'h18;
    localparam logic [7:0] OFS_STATUS = 8'h1C;
    localparam logic [7:0] OFS_INTCLR = 8'h20;
    localparam logic [7:0] OFS_INTEN = 8'h24;

    // ==========================================================
    // Field positions
    localparam int MODE_ENABLE_BIT = 0;
    localparam int MODE_RESETEN_BIT = 1;
    localparam int MODE_WINDOWEN_BIT = 2;
    localparam int MODE_WARNEN_BIT = 3;
    localparam int ST_TIMEOUT_BIT = 0;
    localparam int ST_FAULT_BIT = 1;
    localparam int ST_WARN_BIT = 2;
    localparam int ST_CAUSE_BIT = 3;
    localparam int ST_WIDTH = 4;

    // ==========================================================
    // Reset values and limits
    localparam logic [23:0] TIMEOUT_MIN = 24'h0000FF;
    localparam logic [23:0] TIMEOUT_RST = 24'h0000FF;
    localparam logic [23:0] WINDOW_RST = 24'hFFFFFF;
    localparam logic [23:0] WARN_RST = 24'h000000;
    localparam logic [1:0] CLKSEL_RC = 2'h0;
    localparam logic [1:0] CLKSEL_GUARD = 2'h1;
    localparam logic [1:0] CLKSEL_MAIN = 2'h2;

    // ==========================================================
    // Feed keys and timing
    localparam logic [7:0] FEED_KEY_FIRST = 8'hAA;
    localparam logic [7:0] FEED_KEY_SECOND = 8'h55;
    localparam int PRESCALE_DIV = 4;
    localparam int RESET_PULSE_NS = 80;
    localparam int SYS_CLK_HZ = 50000000;
    localparam int RESET_PULSE_CYC = (RESET_PULSE_NS * (SYS_CLK_HZ / 1000000) + 999) / 1000;

    // ==========================================================
    // Types
    typedef struct packed {
        logic warnEn;
        logic windowEn;
        logic resetEn;
        logic enable;
    } wdg_mode_t;

    typedef struct packed {
        logic timeout;
        logic fault;
        logic warn;
        logic cause;
    } wdg_event_t;

endpackage

// >>> logic/wdg_prescale.sv
/*
 * Tick generator: picks the guard tick clock source, synchronises the
 * asynchronous oscillator pins and divides by the fixed prescale ratio.
 * Assumes oscillator inputs well below half the sys_clk rate.
 */
`timescale 1ns/1ps
module wdg_prescale #(
    parameter int DIV = 4
) (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic internalRcOsc,
    input wire logic dedicatedGuardOsc,
    input wire logic [1:0] clkSel,
    output logic tick
);
    // ==========================================================
    // Synchronisers, stage 1 is read only by stage 2
    logic [2:0] rcSyncQ;
    logic [2:0] grdSyncQ;
    localparam int DIV_W = $clog2(DIV);
    logic srcEdge;
    logic [DIV_W-1:0] divQ;

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            rcSyncQ <= 3'h0;
            grdSyncQ <= 3'h0;
        end else begin
            rcSyncQ <= {rcSyncQ[1:0], internalRcOsc};
            grdSyncQ <= {grdSyncQ[1:0], dedicatedGuardOsc};
        end
    end

    // Main clock source counts every sys_clk period
    always_comb begin
        unique case (clkSel)
            wdg_pkg::CLKSEL_GUARD: srcEdge = grdSyncQ[1] & ~grdSyncQ[2];
            wdg_pkg::CLKSEL_MAIN: srcEdge = 1'b1;
            default: srcEdge = rcSyncQ[1] & ~rcSyncQ[2];
        endcase
    end

    // ==========================================================
    // Fixed divide by DIV source periods per count
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            divQ <= '0;
            tick <= 1'b0;
        end else begin
            tick <= 1'b0;
            if (srcEdge) begin
                if (divQ == DIV_W'(DIV - 1)) begin
                    divQ <= '0;
                    tick <= 1'b1;
                end else begin
                    divQ <= divQ + 1'b1;
                end
            end
        end
    end
endmodule

// >>> logic/wdg_feed_seq.sv
/*
 * Reload key checker: two key writes in immediate succession form a
 * valid reload; a wrong key or an intervening write is a bad sequence.
 * Assumes one-cycle write strobes from the register slave.
 */
`timescale 1ns/1ps
module wdg_feed_seq (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic keyWr,
    input wire logic otherWr,
    input wire logic [7:0] keyData,
    output logic feedOk,
    output logic feedBad
);
    typedef enum logic {SEQ_IDLE, SEQ_ARMED} wdg_seq_t;
    wdg_seq_t stateQ;

    // ==========================================================
    // Sequence state, outputs are single-cycle pulses
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            stateQ <= SEQ_IDLE;
            feedOk <= 1'b0;
            feedBad <= 1'b0;
        end else begin
            feedOk <= 1'b0;
            feedBad <= 1'b0;
            unique case (stateQ)
                SEQ_IDLE: begin
                    if (keyWr) begin
                        if (keyData == wdg_pkg::FEED_KEY_FIRST) begin
                            stateQ <= SEQ_ARMED;
                        end else begin
                            feedBad <= 1'b1;
                        end
                    end
                end
                SEQ_ARMED: begin
                    stateQ <= SEQ_IDLE;
                    if (keyWr) begin
                        feedOk <= (keyData == wdg_pkg::FEED_KEY_SECOND);
                        feedBad <= (keyData != wdg_pkg::FEED_KEY_SECOND);
                    end else if (otherWr) begin
                        // Any other register write breaks the pair
                        feedBad <= 1'b1;
                    end else begin
                        stateQ <= SEQ_ARMED;
                    end
                end
            endcase
        end
    end
endmodule

// >>> tb/tb.sv
/*
 * Self-checking bench for the windowed guard timer top: APB register tasks,
 * reset values, feed, window, warning, interrupt and reset request checks.
 * Drives both oscillator pins from a cycle counter; RC toggles every two cycles.
 */
`timescale 1ns/1ps
module tb;
    logic sys_clk = 1'b0;
    logic rstn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h00000000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic internalRcOsc = 1'b0;
    logic dedicatedGuardOsc = 1'b0;
    logic guardIrq;
    logic guardResetReq;
    logic [2:0] oscCnt = 3'h0;
    logic [31:0] rd;
    logic err;
    int n_mismatch = 0;
    int tests_run = 0;
    int w;

    wdg_top #(.WINDOWED(1'b1)) i_wdg_top (.sys_clk(sys_clk), .rstn(rstn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .internalRcOsc(internalRcOsc),
        .dedicatedGuardOsc(dedicatedGuardOsc), .guardIrq(guardIrq),
        .guardResetReq(guardResetReq));

    always #10 sys_clk = ~sys_clk;

    // ==========================================================
    // Oscillator pins, slow enough for the two-stage synchroniser
    always @(posedge sys_clk) begin
        oscCnt <= oscCnt + 3'h1;
        internalRcOsc <= oscCnt[1];
        dedicatedGuardOsc <= oscCnt[2];
    end

    // ==========================================================
    // Tasks
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic stop_test;
        $display("checks %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    task automatic do_reset;
        @(posedge sys_clk);
        rstn <= 1'b0;
        repeat (12) @(posedge sys_clk);
        rstn <= 1'b1;
    endtask

    // No wait-state count is assumed; only the loop bound cuts a hang
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge sys_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) chk("pready", 32'h0, 32'h1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(what, rd, exp);
    endtask

    task automatic wait_out(input bit useRst, input int lim);
        w = 0;
        do begin
            @(posedge sys_clk);
            w++;
        end while ((useRst ? guardResetReq : guardIrq) !== 1'b1 && w < lim);
        chk(useRst ? "resetReq" : "irq", {31'h0, w < lim}, 32'h1);
    endtask

    task automatic pulse_len;
        w = 1;
        while (guardResetReq === 1'b1 && w < 20) begin
            @(posedge sys_clk);
            if (guardResetReq === 1'b1) w++;
        end
        chk("resetLen", w, wdg_pkg::RESET_PULSE_CYC);
    endtask

    // ==========================================================
    // Tests
    logic [7:0] rAddr [8] = '{8'h00, 8'h04, 8'h14, 8'h18, 8'h10, 8'h24, 8'h1C, 8'h0C};
    logic [31:0] rExp [8] = '{32'h0, 32'hFF, 32'hFFFFFF, 32'h0, 32'h0, 32'h0, 32'h0, 32'hFF};

    initial begin
        do_reset();
        for (int i = 0; i < 8; i++) rdchk("resetVal", rAddr[i], rExp[i]);
        apb(1'b0, 8'h28, 32'h0);
        chk("unmappedErr", {31'h0, err}, 32'h1);
        wr(8'h10, 32'h2);
        rdchk("clkselMain", 8'h10, 32'h0);
        wr(8'h10, 32'h1);
        rdchk("clkselGuard", 8'h10, 32'h1);
        wr(8'h10, 32'h3);
        rdchk("clkselBad", 8'h10, 32'h0);
        wr(8'h04, 32'h10);
        rdchk("timeoutMin", 8'h04, 32'hFF);
        wr(8'h04, 32'h100);
        rdchk("countIdle", 8'h0C, 32'h100);
        wr(8'h24, 32'h1);
        wr(8'h00, 32'h1);
        wr(8'h00, 32'h0);
        rdchk("enableSticky", 8'h00, 32'h1);
        repeat (100) @(posedge sys_clk);
        apb(1'b0, 8'h0C, 32'h0);
        chk("countDown", {31'h0, rd < 32'h100 && rd > 32'hF6}, 32'h1);
        wr(8'h08, 32'hAA);
        wr(8'h08, 32'h55);
        apb(1'b0, 8'h0C, 32'h0);
        chk("reload", {31'h0, rd >= 32'hFF && rd <= 32'h100}, 32'h1);
        rdchk("noFault", 8'h1C, 32'h0);
        wait_out(1'b0, 6000);
        rdchk("expireSt", 8'h1C, 32'h1);
        rdchk("enableOff", 8'h00, 32'h0);
        chk("noResetReq", {31'h0, guardResetReq}, 32'h0);
        wr(8'h20, 32'h1);
        repeat (2) @(posedge sys_clk);
        chk("irqCleared", {31'h0, guardIrq}, 32'h0);
        rdchk("stCleared", 8'h1C, 32'h0);

        // Timeout in reset mode
        do_reset();
        wr(8'h00, 32'h3);
        wait_out(1'b1, 6000);
        pulse_len();
        rdchk("causeTimeout", 8'h1C, 32'h9);
        rdchk("enableOffRst", 8'h00, 32'h2);

        // Bad key in reset mode, then an intervening write in interrupt mode
        for (int v = 0; v < 2; v++) begin
            do_reset();
            wr(8'h24, 32'h2);
            wr(8'h00, v ? 32'h1 : 32'h3);
            wr(8'h08, 32'hAA);
            if (v) wr(8'h18, 32'h5);
            wr(8'h08, v ? 32'h55 : 32'h12);
            wait_out(v == 0, 50);
            rdchk("faultSt", 8'h1C, v ? 32'h2 : 32'hA);
        end

        // Window: in-window reload accepted, early reload refused
        do_reset();
        wr(8'h14, 32'hF8);
        wr(8'h04, 32'h100);
        wr(8'h24, 32'h2);
        wr(8'h00, 32'h5);
        w = 0;
        do begin
            apb(1'b0, 8'h0C, 32'h0);
            w++;
        end while (rd > 32'hF8 && w < 200);
        wr(8'h08, 32'hAA);
        wr(8'h08, 32'h55);
        rdchk("inWindow", 8'h1C, 32'h0);
        wr(8'h08, 32'hAA);
        wr(8'h08, 32'h55);
        wait_out(1'b0, 50);
        rdchk("earlyFeed", 8'h1C, 32'h2);

        // Warning, masking and clearing
        do_reset();
        wr(8'h10, 32'h1);
        wr(8'h18, 32'hF0);
        wr(8'h04, 32'h100);
        wr(8'h24, 32'h4);
        wr(8'h00, 32'h9);
        wait_out(1'b0, 800);
        // Guard pin ticks every 32 cycles, so 16 steps take far longer than on RC
        chk("guardRate", {31'h0, w > 400}, 32'h1);
        rdchk("warnSt", 8'h1C, 32'h4);
        wr(8'h24, 32'h0);
        repeat (2) @(posedge sys_clk);
        chk("irqMasked", {31'h0, guardIrq}, 32'h0);
        wr(8'h20, 32'h4);
        rdchk("warnClr", 8'h1C, 32'h0);
        stop_test();
    end

    // Whole run is about 10k cycles; the limit leaves a wide margin
    initial begin
        repeat (90000) @(posedge sys_clk);
        n_mismatch++;
        stop_test();
    end
endmodule
